// [core/ldsd_regs.sv]
// Register bank for two LDO control registers and the first buck discharge register,
// with its own two-wire serial target.
// Assumes serial pins synchronous to clock_i after the on-chip synchronisers and
// regulator enable requests already decoded from the control input pins.

//////////////////////////////////////////////////////////////////////////////////////////

// Contract
// - Sleep select 00 always applies the normal voltage code.
// - Sleep select 11 applies sleep code while assigned sleep pin is low.
// - Sleep pin choice per regulator is fixed at build, not by software.
// - Permit bit 0 low forces regulator off regardless of control pins.
// - First LDO control at 28h; select 5:4, permit 0, 7:6 read zero.
// - Second LDO control at 29h with identical layout and behaviour.
// - Discharge register at 40h holds four 2-bit buck fields.
// - Discharge codes: 00 none, 01 100, 10 200, 11 500 ohms.
// - Discharge field forced to 00 while its regulator is enabled.
module ldsd_regs #(
  parameter logic LDO_TWO_SLEEP_ON_PIN_TWO   = 1'b0,
  parameter logic LDO_THREE_SLEEP_ON_PIN_TWO = 1'b1
) (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       clk_en_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       sleep_pin_one_i,
  input  wire logic       sleep_pin_two_i,
  input  wire logic       ldo_two_request_i,
  input  wire logic       ldo_three_request_i,
  input  wire logic [7:0] ldo_two_normal_voltage_code_i,
  input  wire logic [7:0] ldo_two_sleep_voltage_code_i,
  input  wire logic [7:0] ldo_three_normal_voltage_code_i,
  input  wire logic [7:0] ldo_three_sleep_voltage_code_i,
  input  wire logic [3:0] buck_enabled_i,
  output logic            ldo_two_enable_o,
  output logic            ldo_three_enable_o,
  output logic            ldo_two_sleep_active_o,
  output logic            ldo_three_sleep_active_o,
  output logic [7:0]      ldo_two_voltage_code_o,
  output logic [7:0]      ldo_three_voltage_code_o,
  output logic [1:0]      buck_one_discharge_select_o,
  output logic [1:0]      buck_two_discharge_select_o,
  output logic [1:0]      buck_three_discharge_select_o,
  output logic [1:0]      buck_four_discharge_select_o
);
  import ldsd_pkg::*;

  ldsd_regs_t q;
  ldsd_regs_t d;

  //////////////////////////////////////////////////////////////////////////////////////

  function automatic logic [7:0] reg_read(input ldsd_regs_t s, input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      LDSD_OFS_LDO_TWO:   v = s.ldo_two_ctrl & LDSD_LDO_WRITE_MASK;
      LDSD_OFS_LDO_THREE: v = s.ldo_three_ctrl & LDSD_LDO_WRITE_MASK;
      LDSD_OFS_DISCHARGE: v = s.discharge;
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  // Only 11 selects the sleep code; the reserved codes behave like 00.
  function automatic logic sleep_wanted(input logic [7:0] ctrl, input logic pin_low);
    return (ctrl[LDSD_SLP_LSB +: 2] == LDSD_SLP_ENABLED) && pin_low;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_now;
  logic pin_low_two;
  logic pin_low_three;
  logic [7:0] rd;

  always_comb begin
    d = q;
    rd = 8'h00;
    d.scl_s = {q.scl_s[1:0], scl_i};
    d.sda_s = {q.sda_s[1:0], sda_i};
    d.sda_lvl = 1'b0;
    sda_now   = q.sda_s[1];
    scl_rise  = q.scl_s[1] & ~q.scl_s[2];
    scl_fall  = ~q.scl_s[1] & q.scl_s[2];
    bus_start = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
    bus_stop  = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];

    if (bus_start) begin
      d.st     = LDSD_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.st     = LDSD_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        LDSD_ADDR, LDSD_REG, LDSD_WDATA: begin
          d.sh  = {q.sh[6:0], sda_now};
          d.cnt = q.cnt + 4'h1;
        end
        LDSD_RDATA: d.cnt = q.cnt + 4'h1;
        LDSD_RACK:  d.nack = sda_now;
        default:    d.cnt = q.cnt;
      endcase
    end else if (scl_fall) begin
      case (q.st)
        LDSD_ADDR: begin
          if (q.cnt == LDSD_BITS_PER_BYTE) begin
            if (q.sh[7:1] == LDSD_BUS_ADDR) begin
              d.st     = LDSD_ACK_ADDR;
              d.sda_oe = 1'b1;
            end else begin
              d.st = LDSD_IDLE;
            end
          end
        end
        LDSD_ACK_ADDR: begin
          d.cnt = 4'h0;
          if (q.sh[0]) begin
            rd       = reg_read(q, q.ptr);
            d.sh     = rd;
            d.sda_oe = ~rd[7];
            d.st     = LDSD_RDATA;
          end else begin
            d.sda_oe = 1'b0;
            d.st     = LDSD_REG;
          end
        end
        LDSD_REG: begin
          if (q.cnt == LDSD_BITS_PER_BYTE) begin
            d.ptr    = q.sh;
            d.sda_oe = 1'b1;
            d.st     = LDSD_ACK_REG;
          end
        end
        LDSD_ACK_REG, LDSD_ACK_WDATA: begin
          d.sda_oe = 1'b0;
          d.cnt    = 4'h0;
          d.st     = LDSD_WDATA;
        end
        LDSD_WDATA: begin
          if (q.cnt == LDSD_BITS_PER_BYTE) begin
            case (q.ptr)
              LDSD_OFS_LDO_TWO:   d.ldo_two_ctrl   = q.sh & LDSD_LDO_WRITE_MASK;
              LDSD_OFS_LDO_THREE: d.ldo_three_ctrl = q.sh & LDSD_LDO_WRITE_MASK;
              LDSD_OFS_DISCHARGE: d.discharge      = q.sh;
              default:            d.discharge      = q.discharge;
            endcase
            d.ptr    = q.ptr + 8'h01;
            d.sda_oe = 1'b1;
            d.st     = LDSD_ACK_WDATA;
          end
        end
        LDSD_RDATA: begin
          if (q.cnt == LDSD_BITS_PER_BYTE) begin
            d.sda_oe = 1'b0;
            d.ptr    = q.ptr + 8'h01;
            d.st     = LDSD_RACK;
          end else begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
        LDSD_RACK: begin
          d.cnt = 4'h0;
          if (q.nack) begin
            d.st = LDSD_IDLE;
          end else begin
            rd       = reg_read(q, q.ptr);
            d.sh     = rd;
            d.sda_oe = ~rd[7];
            d.st     = LDSD_RDATA;
          end
        end
        default: d.st = LDSD_IDLE;
      endcase
    end

    // An enabled buck clears its discharge field, even against a write in the same cycle.
    for (int k = 0; k < 4; k++) begin
      if (buck_enabled_i[k]) begin
        d.discharge[2*k +: 2] = LDSD_DIS_NONE;
      end
    end

    pin_low_two   = ~(LDO_TWO_SLEEP_ON_PIN_TWO ? sleep_pin_two_i : sleep_pin_one_i);
    pin_low_three = ~(LDO_THREE_SLEEP_ON_PIN_TWO ? sleep_pin_two_i : sleep_pin_one_i);
    d.ldo_two_en    = ldo_two_request_i & d.ldo_two_ctrl[LDSD_PERMIT_BIT];
    d.ldo_three_en  = ldo_three_request_i & d.ldo_three_ctrl[LDSD_PERMIT_BIT];
    d.ldo_two_slp   = sleep_wanted(d.ldo_two_ctrl, pin_low_two);
    d.ldo_three_slp = sleep_wanted(d.ldo_three_ctrl, pin_low_three);
    d.ldo_two_code   = d.ldo_two_slp ? ldo_two_sleep_voltage_code_i
                                     : ldo_two_normal_voltage_code_i;
    d.ldo_three_code = d.ldo_three_slp ? ldo_three_sleep_voltage_code_i
                                       : ldo_three_normal_voltage_code_i;
  end

  //////////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      q                <= '0;
      q.st             <= LDSD_IDLE;
      q.scl_s          <= 3'h7;
      q.sda_s          <= 3'h7;
      q.ldo_two_ctrl   <= LDSD_RST_LDO_CTRL;
      q.ldo_three_ctrl <= LDSD_RST_LDO_CTRL;
      q.discharge      <= LDSD_RST_DISCHARGE;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign sda_o                         = q.sda_lvl;
  assign sda_oe_o                      = q.sda_oe;
  assign ldo_two_enable_o              = q.ldo_two_en;
  assign ldo_three_enable_o            = q.ldo_three_en;
  assign ldo_two_sleep_active_o        = q.ldo_two_slp;
  assign ldo_three_sleep_active_o      = q.ldo_three_slp;
  assign ldo_two_voltage_code_o        = q.ldo_two_code;
  assign ldo_three_voltage_code_o      = q.ldo_three_code;
  assign buck_one_discharge_select_o   = q.discharge[1:0];
  assign buck_two_discharge_select_o   = q.discharge[3:2];
  assign buck_three_discharge_select_o = q.discharge[5:4];
  assign buck_four_discharge_select_o  = q.discharge[7:6];

endmodule

// [shared/ldsd_pkg.sv]
// Constants and types for the regulator sleep and discharge register bank.
// Assumes an 8-bit register space reached over a two-wire serial target.
package ldsd_pkg;

  localparam logic [7:0] LDSD_OFS_LDO_TWO      = 8'h28;
  localparam logic [7:0] LDSD_OFS_LDO_THREE    = 8'h29;
  localparam logic [7:0] LDSD_OFS_DISCHARGE    = 8'h40;

  localparam logic [7:0] LDSD_RST_LDO_CTRL     = 8'h0c;
  localparam logic [7:0] LDSD_RST_DISCHARGE    = 8'h00;

  // Control register fields.
  localparam int         LDSD_SLP_LSB          = 4;
  localparam int         LDSD_PERMIT_BIT       = 0;
  localparam logic [7:0] LDSD_LDO_WRITE_MASK   = 8'h3f;
  localparam logic [1:0] LDSD_SLP_ENABLED      = 2'h3;

  // Discharge field codes: none, 100 ohm, 200 ohm, 500 ohm.
  localparam logic [1:0] LDSD_DIS_NONE         = 2'h0;
  localparam logic [1:0] LDSD_DIS_100          = 2'h1;
  localparam logic [1:0] LDSD_DIS_200          = 2'h2;
  localparam logic [1:0] LDSD_DIS_500          = 2'h3;

  // Target address on the serial bus; the value is arbitrary.
  localparam logic [6:0] LDSD_BUS_ADDR         = 7'h2a;
  localparam logic [3:0] LDSD_BITS_PER_BYTE    = 4'h8;

  typedef enum logic [3:0] {
    LDSD_IDLE,
    LDSD_ADDR,
    LDSD_ACK_ADDR,
    LDSD_REG,
    LDSD_ACK_REG,
    LDSD_WDATA,
    LDSD_ACK_WDATA,
    LDSD_RDATA,
    LDSD_RACK
  } ldsd_state_t;

  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    ldsd_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        nack;
    logic        sda_oe;
    logic        sda_lvl;
    logic [7:0]  ldo_two_ctrl;
    logic [7:0]  ldo_three_ctrl;
    logic [7:0]  discharge;
    logic        ldo_two_en;
    logic        ldo_three_en;
    logic        ldo_two_slp;
    logic        ldo_three_slp;
    logic [7:0]  ldo_two_code;
    logic [7:0]  ldo_three_code;
  } ldsd_regs_t;

endpackage

// [verification/ldsd_regs_properties.sv]
// Port checks for the regulator sleep and discharge register bank.
// Assumes the default straps: ldo two sleeps on pin one, ldo three on pin two.
module ldsd_regs_properties (
  input logic       clock_i,
  input logic       nrst_i,
  input logic       clk_en_i,
  input logic       sleep_pin_one_i,
  input logic       sleep_pin_two_i,
  input logic       ldo_two_request_i,
  input logic       ldo_three_request_i,
  input logic [3:0] buck_enabled_i,
  input logic       ldo_two_enable_o,
  input logic       ldo_three_enable_o,
  input logic       ldo_two_sleep_active_o,
  input logic       ldo_three_sleep_active_o,
  input logic [1:0] buck_one_discharge_select_o,
  input logic [1:0] buck_two_discharge_select_o,
  input logic [1:0] buck_three_discharge_select_o,
  input logic [1:0] buck_four_discharge_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  a_two_needs_req: assert property (clk_en_i && !ldo_two_request_i |=> !ldo_two_enable_o)
    else $error("ldo two on without request");
  a_three_needs_req: assert property (clk_en_i ##1 !$past(ldo_three_request_i) |-> !ldo_three_enable_o)
    else $error("ldo three on without request");
  a_two_sleep_pin: assert property (clk_en_i && sleep_pin_one_i |=> !ldo_two_sleep_active_o)
    else $error("ldo two sleeps with pin high");
  a_three_sleep_pin: assert property (clk_en_i && sleep_pin_two_i |=> !ldo_three_sleep_active_o)
    else $error("ldo three sleeps with pin high");
  a_buck_one_clear: assert property (clk_en_i && buck_enabled_i[0] |=> buck_one_discharge_select_o == 2'h0)
    else $error("buck one discharge kept");
  a_buck_two_clear: assert property (clk_en_i && buck_enabled_i[1] [*2] |=> buck_two_discharge_select_o == 2'h0)
    else $error("buck two discharge kept");
  a_buck_three_clear: assert property (clk_en_i && buck_enabled_i[2] |=> buck_three_discharge_select_o == 2'h0)
    else $error("buck three discharge kept");
  a_buck_four_clear: assert property (clk_en_i && buck_enabled_i[3] |=> buck_four_discharge_select_o == 2'h0)
    else $error("buck four discharge kept");
  c_two_sleep: cover property (ldo_two_sleep_active_o);
  c_three_on: cover property (ldo_three_enable_o);
  c_buck_cleared: cover property (buck_enabled_i[1] ##2 buck_two_discharge_select_o == 2'h0);
endmodule
bind ldsd_regs ldsd_regs_properties u_props (.*);

// [verification/ldsd_host_model.sv]
// Two-wire bus host that reaches the register bank.
// Assumes the bench resolves the data line with a pull-up.
module ldsd_host_model (
  input  logic clock_i,
  input  logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldsd_pkg::*;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic bt(input logic b, output logic r);
    pull_o = !b;
    wt(6);
    scl_o = 1'b1;
    wt(6);
    r = sda_i;
    scl_o = 1'b0;
    wt(1);
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] r, inout logic nak);
    logic a;
    for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
    bt(1'b1, a);
    nak |= a;
  endtask
  task automatic st;
    pull_o = 1'b0;
    wt(6);
    scl_o = 1'b1;
    wt(6);
    pull_o = 1'b1;
    wt(6);
    scl_o = 1'b0;
    wt(1);
  endtask
  task automatic sp;
    pull_o = 1'b1;
    wt(6);
    scl_o = 1'b1;
    wt(6);
    pull_o = 1'b0;
    wt(6);
  endtask
  task automatic write_reg(input logic [7:0] o, d, output logic nak);
    logic [7:0] r;
    nak = 1'b0;
    st;
    by({LDSD_BUS_ADDR, 1'b0}, r, nak);
    by(o, r, nak);
    by(d, r, nak);
    sp;
  endtask
  task automatic read_reg(input logic [7:0] o, output logic [7:0] d);
    logic x;
    x = 1'b0;
    st;
    by({LDSD_BUS_ADDR, 1'b0}, d, x);
    by(o, d, x);
    st;
    by({LDSD_BUS_ADDR, 1'b1}, d, x);
    by(8'hff, d, x);
    sp;
  endtask
endmodule

// [verification/ldsd_regs_bench.sv]
// Self-checking bench for the regulator sleep and discharge register bank.
// Assumes the host model drives the serial pins; the data line has a pull-up.
module ldsd_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, scl, pull, p1 = 1'b1, p2 = 1'b1, rq2 = 1'b0, rq3 = 1'b0;
  logic       oe, en2, en3, s2, s3, nak;
  logic       ce = 1'b1;
  logic [3:0] bk = 4'h0;
  logic [7:0] c2, c3, v;
  logic [1:0] ds [4];
  int         bad_count = 0, comparisons = 0;
  wire        sda = !(oe | pull);
  always #2 clk = !clk;
  ldsd_regs u_dut (.clock_i(clk), .nrst_i(rst_n), .clk_en_i(ce), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(oe), .sleep_pin_one_i(p1), .sleep_pin_two_i(p2), .ldo_two_request_i(rq2), .ldo_three_request_i(rq3),
    .ldo_two_normal_voltage_code_i(8'h11), .ldo_two_sleep_voltage_code_i(8'h22), .ldo_three_normal_voltage_code_i(8'h33),
    .ldo_three_sleep_voltage_code_i(8'h44), .buck_enabled_i(bk), .ldo_two_enable_o(en2), .ldo_three_enable_o(en3),
    .ldo_two_sleep_active_o(s2), .ldo_three_sleep_active_o(s3), .ldo_two_voltage_code_o(c2),
    .ldo_three_voltage_code_o(c3), .buck_one_discharge_select_o(ds[0]), .buck_two_discharge_select_o(ds[1]),
    .buck_three_discharge_select_o(ds[2]), .buck_four_discharge_select_o(ds[3]));
  ldsd_host_model u_host (.clock_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] o, d);
    u_host.write_reg(o, d, nak);
    chk("write ack", 8'h0, {7'h0, nak});
  endtask
  task automatic rd(input logic [7:0] o, e);
    u_host.read_reg(o, v);
    chk("read data", e, v);
  endtask
  task automatic w2;
    repeat (2) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rq2 = 1'b1;
    rq3 = 1'b1;
    repeat (3) @(negedge clk);
    chk("enable two", 8'h0, {7'h0, en2});
    rd(8'h28, 8'h0c);
    rd(8'h29, 8'h0c);
    rd(8'h40, 8'h00);
    wr(8'h28, 8'hcd);
    rd(8'h28, 8'h0d);
    wr(8'h41, 8'h55);
    rd(8'h41, 8'h00);
    p1 = 1'b0;
    w2;
    chk("enable two", 8'h1, {7'h0, en2});
    chk("code two", 8'h11, c2);
    wr(8'h28, 8'h3d);
    wr(8'h29, 8'h3d);
    chk("code two", 8'h22, c2);
    chk("code three", 8'h33, c3);
    p1 = 1'b1;
    p2 = 1'b0;
    w2;
    chk("code two", 8'h11, c2);
    chk("code three", 8'h44, c3);
    wr(8'h29, 8'h3c);
    chk("enable three", 8'h0, {7'h0, en3});
    wr(8'h40, 8'he4);
    for (int i = 0; i < 4; i++) chk("discharge", {6'h0, 2'(i)}, {6'h0, ds[i]});
    bk = 4'h6;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) chk("cleared", {6'h0, bk[i] ? 2'h0 : 2'(i)}, {6'h0, ds[i]});
    bk = 4'h0;
    rd(8'h40, 8'hc0);
    wr(8'h40, 8'he4);
    bk = 4'h9;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) chk("cleared", {6'h0, bk[i] ? 2'h0 : 2'(i)}, {6'h0, ds[i]});
    bk = 4'h0;
    ce = 1'b0;
    rq2 = 1'b0;
    w2;
    chk("frozen enable two", 8'h1, {7'h0, en2});
    ce = 1'b1;
    w2;
    chk("enable two", 8'h0, {7'h0, en2});
    end_sim;
  end
endmodule
